/* common/wdt_pkg.sv */
// Package: constants, register map and helpers of the watchdog block
package wdt_pkg;

  // Clock and low-power tick timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned LPO_PERIOD_NS = 1000000;
  localparam int unsigned LPO_CYCLES    = LPO_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned DIV_W         = 17;

  // Overflow exponents: low-power clock short/long, bus clock short/long
  localparam int unsigned LOG_LPO_SHORT = 5;
  localparam int unsigned LOG_LPO_LONG  = 8;
  localparam int unsigned LOG_BUS_SHORT = 13;
  localparam int unsigned LOG_BUS_LONG  = 18;
  localparam int unsigned CNT_W         = 18;

  // Avalon-MM geometry and byte addresses
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] ADR_OPT1  = 5'h00;
  localparam logic [ADDR_W-1:0] ADR_OPT2  = 5'h04;
  localparam logic [ADDR_W-1:0] ADR_RSS   = 5'h08;
  localparam logic [ADDR_W-1:0] ADR_ISTS  = 5'h0c;
  localparam logic [ADDR_W-1:0] ADR_IMASK = 5'h10;
  localparam logic [ADDR_W-1:0] ADR_CNT   = 5'h14;

  // Field positions
  localparam int unsigned OPT1_EN_BIT    = 0;
  localparam int unsigned OPT1_TLONG_BIT = 1;
  localparam int unsigned OPT2_CLKS_BIT  = 0;
  localparam int unsigned RSS_WDT_BIT    = 0;

  // Reset values; clock select 0 is the low-power clock, 1 the bus clock
  localparam logic RST_EN    = 1'b1;
  localparam logic RST_TLONG = 1'b1;
  localparam logic RST_CLKS  = 1'b0;

  // Interrupt event bits
  localparam int unsigned EV_W      = 3;
  localparam int unsigned EV_OVF    = 0;
  localparam int unsigned EV_SVC    = 1;
  localparam int unsigned EV_LOCKED = 2;

  // Terminal count for an overflow of 2**lg counting cycles
  function automatic logic [CNT_W-1:0] wdt_limit(input int unsigned lg);
    logic [63:0] v;
    v = (64'h1 << lg) - 64'h1;
    return v[CNT_W-1:0];
  endfunction

endpackage

/* common/wdt_tick_if.sv */
// Interface: low-power tick between the divider and the watchdog core
`timescale 1ns/10ps
`default_nettype none
interface wdt_tick_if;
  logic run;
  logic tick;
  modport gen (input run, output tick);
  modport use_tick (output run, input tick);
endinterface // wdt_tick_if
`default_nettype wire

/* hdl/wdt_lpo_div.sv */
// Divider: one-cycle tick at the low-power clock rate
`timescale 1ns/10ps
`default_nettype none
module wdt_lpo_div #(
  parameter int unsigned P_CYCLES = wdt_pkg::LPO_CYCLES
) (
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  wdt_tick_if.gen   tk
);
  import wdt_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } wdt_div_t;

  localparam logic [DIV_W-1:0] LAST = DIV_W'(P_CYCLES - 1);

  wdt_div_t s_r;
  wdt_div_t s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    // Idle divider restarts so the first tick is a full period away
    if (!tk.run) begin
      s_nxt.cnt = '0;
    end else if (s_r.cnt == LAST) begin
      s_nxt.cnt  = '0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tk.tick = s_r.tick;

endmodule // wdt_lpo_div
`default_nettype wire

/* hdl/wdt_top.sv */
// Watchdog timer with write-once options and Avalon-MM registers
//
// Register access over Avalon-MM and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module wdt_top #(
  parameter int unsigned P_LPO_CYCLES  = wdt_pkg::LPO_CYCLES,
  parameter int unsigned P_BUS_SHORT_LG = wdt_pkg::LOG_BUS_SHORT,
  parameter int unsigned P_BUS_LONG_LG  = wdt_pkg::LOG_BUS_LONG
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_arst_n,
  input  wire logic                       i_sys_rst,
  input  wire logic                       i_debug,
  input  wire logic                       i_stop,
  input  wire logic [wdt_pkg::ADDR_W-1:0] i_avs_address,
  input  wire logic                       i_avs_read,
  input  wire logic                       i_avs_write,
  input  wire logic [wdt_pkg::DATA_W-1:0] i_avs_writedata,
  input  wire logic [3:0]                 i_avs_byteenable,
  output logic      [wdt_pkg::DATA_W-1:0] o_avs_readdata,
  output logic                            o_avs_waitrequest,
  output logic                            o_irq,
  output logic                            o_wdt_reset_req
);
  import wdt_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic              en;
    logic              tlong;
    logic              clks;
    logic              lock1;
    logic              lock2;
    logic [CNT_W-1:0]  cnt;
    logic              req;
    logic              cause;
    logic              rss_wdt;
    logic              stop_q;
    logic              sys_q;
    logic [EV_W-1:0]   ists;
    logic [EV_W-1:0]   imask;
    logic              irq;
    logic              wait_q;
    logic [DATA_W-1:0] rdata;
  } wdt_state_t;

  localparam wdt_state_t RST_STATE = '{
    en: RST_EN, tlong: RST_TLONG, clks: RST_CLKS, wait_q: 1'b1,
    default: '0};

  wdt_state_t       s_r;
  wdt_state_t       s_nxt;
  logic [CNT_W-1:0] lim_c;
  logic             tick_c;
  logic             acc_c;
  logic             wr_c;
  logic             rd_c;
  logic             be0_c;
  logic             first1_c;
  logic             first2_c;
  logic             svc_c;
  logic             clr_c;
  logic             stop_ent_c;
  logic             run_c;
  logic             ovf_c;
  logic [EV_W-1:0]  ev_c;

  wdt_tick_if tk ();

  wdt_lpo_div #(
    .P_CYCLES (P_LPO_CYCLES)
  ) u_div (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .tk       (tk.gen)
  );

  ////////////////////////////////////////////////////////////////////////
  // counting clock select
  assign tk.run = ~s_r.clks;
  assign tick_c = s_r.clks | tk.tick;

  always_comb begin
    unique case ({s_r.clks, s_r.tlong})
      2'b00: lim_c = wdt_limit(LOG_LPO_SHORT);
      2'b01: lim_c = wdt_limit(LOG_LPO_LONG);
      2'b10: lim_c = wdt_limit(P_BUS_SHORT_LG);
      2'b11: lim_c = wdt_limit(P_BUS_LONG_LG);
    endcase
  end

  // A write takes effect at the edge where waitrequest is seen low
  assign acc_c = (i_avs_read | i_avs_write) & ~s_r.wait_q;
  assign wr_c  = acc_c & i_avs_write;
  assign rd_c  = acc_c & i_avs_read;
  assign be0_c = i_avs_byteenable[0];

  // only the first write after reset is taken
  assign first1_c = wr_c & (i_avs_address == ADR_OPT1) & ~s_r.lock1;
  assign first2_c = wr_c & (i_avs_address == ADR_OPT2) & ~s_r.lock2;
  // any data and any lanes service the counter
  assign svc_c    = wr_c & (i_avs_address == ADR_RSS);
  // initial option writes also clear the counter
  assign clr_c    = svc_c | first1_c | first2_c;

  assign stop_ent_c = i_stop & ~s_r.stop_q;
  // counting needs enable, no debug, no stop
  assign run_c = s_r.en & ~i_debug & ~i_stop & tick_c;
  assign ovf_c = run_c & ~clr_c & (s_r.cnt == lim_c);

  always_comb begin
    ev_c            = '0;
    ev_c[EV_OVF]    = ovf_c;
    ev_c[EV_SVC]    = svc_c;
    ev_c[EV_LOCKED] = wr_c & (((i_avs_address == ADR_OPT1) & s_r.lock1) |
                              ((i_avs_address == ADR_OPT2) & s_r.lock2));
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt        = s_r;
    s_nxt.stop_q = i_stop;
    s_nxt.sys_q  = i_sys_rst;

    // Bus handshake: one wait cycle, then one cycle with waitrequest low
    s_nxt.wait_q = ~((i_avs_read | i_avs_write) & s_r.wait_q);
    if (i_avs_read & s_r.wait_q) begin
      s_nxt.rdata = '0;
      unique case (i_avs_address)
        ADR_OPT1: begin
          s_nxt.rdata[OPT1_EN_BIT]    = s_r.en;
          s_nxt.rdata[OPT1_TLONG_BIT] = s_r.tlong;
        end
        ADR_OPT2:  s_nxt.rdata[OPT2_CLKS_BIT] = s_r.clks;
        ADR_RSS:   s_nxt.rdata[RSS_WDT_BIT]   = s_r.rss_wdt;
        ADR_ISTS:  s_nxt.rdata[EV_W-1:0]      = s_r.ists;
        ADR_IMASK: s_nxt.rdata[EV_W-1:0]      = s_r.imask;
        ADR_CNT:   s_nxt.rdata[CNT_W-1:0]     = s_r.cnt;
        default:   s_nxt.rdata = '0;
      endcase
    end

    // option writes lock whether or not lane 0 is enabled
    if (first1_c) begin
      s_nxt.lock1 = 1'b1;
      if (be0_c) begin
        s_nxt.en    = i_avs_writedata[OPT1_EN_BIT];
        s_nxt.tlong = i_avs_writedata[OPT1_TLONG_BIT];
      end
    end
    if (first2_c) begin
      s_nxt.lock2 = 1'b1;
      if (be0_c) begin
        s_nxt.clks = i_avs_writedata[OPT2_CLKS_BIT];
      end
    end
    if (wr_c && (i_avs_address == ADR_IMASK) && be0_c) begin
      s_nxt.imask = i_avs_writedata[EV_W-1:0];
    end

    // request ends at the next tick of the counting clock
    if (s_r.req && tick_c) begin
      s_nxt.req = 1'b0;
    end

    // Counter; a service beats a stop entry, which beats counting
    if (clr_c) begin
      s_nxt.cnt = '0;
    end else if (!s_r.en) begin
      s_nxt.cnt = '0;
    end else if (stop_ent_c && !s_r.clks) begin
      // low-power clock restarts from zero after stop
      s_nxt.cnt = '0;
    end else if (ovf_c) begin
      s_nxt.cnt   = '0;
      s_nxt.req   = 1'b1;
      s_nxt.cause = 1'b1;
    end else if (run_c) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end

    // Only the bits actually returned by a status read are cleared,
    // so an event landing during the read is kept
    if (rd_c && (i_avs_address == ADR_ISTS)) begin
      s_nxt.ists = s_r.ists & ~s_r.rdata[EV_W-1:0];
    end
    s_nxt.ists = s_nxt.ists | ev_c;

    // any system reset restores the option defaults; mask and status are kept
    if (i_sys_rst) begin
      s_nxt.en    = RST_EN;
      s_nxt.tlong = RST_TLONG;
      s_nxt.clks  = RST_CLKS;
      s_nxt.lock1 = 1'b0;
      s_nxt.lock2 = 1'b0;
      s_nxt.cnt   = '0;
      s_nxt.req   = 1'b0;
      s_nxt.cause = 1'b0;
      // cause sampled on the first reset cycle only
      if (!s_r.sys_q) begin
        s_nxt.rss_wdt = s_r.cause;
      end
    end

    s_nxt.irq = |(s_nxt.ists & s_nxt.imask);
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_r <= RST_STATE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_avs_readdata    = s_r.rdata;
  assign o_avs_waitrequest = s_r.wait_q;
  assign o_irq             = s_r.irq;
  assign o_wdt_reset_req   = s_r.req;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  a_reset_enables: assert property (
    i_sys_rst |=> s_r.en && !s_r.lock1)
    else $error("enable not restored by system reset");

  a_reset_defaults: assert property (
    i_sys_rst |=> !s_r.clks && s_r.tlong && !o_wdt_reset_req)
    else $error("clock or length default wrong after reset");

  a_disabled_quiet: assert property (
    (!s_r.en && !s_r.req && !i_sys_rst) |=> !o_wdt_reset_req && s_r.cnt == '0)
    else $error("disabled watchdog counted or requested reset");

  a_service_clear: assert property (
    (svc_c && !i_sys_rst) |=> s_r.cnt == '0 && $stable(s_r.rss_wdt))
    else $error("service write did not clear counter only");

  a_bus_rate: assert property (
    (s_r.clks && s_r.en && !i_stop && !i_debug && !clr_c && !i_sys_rst &&
     s_r.cnt != lim_c) |=> s_r.cnt == $past(s_r.cnt) + 1'b1)
    else $error("bus clock selection not counting each cycle");

  a_ovf_at_limit: assert property (
    $rose(o_wdt_reset_req) |-> $past(s_r.cnt) == $past(lim_c))
    else $error("overflow not at selected count");

  a_short_bus: assert property (
    ($rose(o_wdt_reset_req) && $past(s_r.clks) && !$past(s_r.tlong))
      |-> $past(s_r.cnt) == CNT_W'((64'h1 << P_BUS_SHORT_LG) - 64'h1))
    else $error("short bus overflow count wrong");

  a_write_once: assert property (
    (wr_c && i_avs_address == ADR_OPT1 && s_r.lock1 && !i_sys_rst)
      |=> $stable(s_r.en) && $stable(s_r.tlong))
    else $error("locked option register changed");

  a_first_clears: assert property (
    (first2_c && !i_sys_rst) |=> s_r.cnt == '0 && s_r.lock2)
    else $error("first option write did not clear and lock");

  a_debug_hold: assert property (
    (i_debug && s_r.en && !clr_c && !i_sys_rst && !stop_ent_c)
      |=> $stable(s_r.cnt))
    else $error("counter moved in debug");

  a_stop_bus_hold: assert property (
    (i_stop && s_r.clks && s_r.en && !clr_c && !i_sys_rst)
      |=> $stable(s_r.cnt))
    else $error("bus clock counter moved in stop");

  a_stop_lpo_zero: assert property (
    (stop_ent_c && !s_r.clks && !i_sys_rst) |=> s_r.cnt == '0)
    else $error("low-power counter not zeroed at stop entry");

  a_ovf_enabled: assert property (
    $rose(o_wdt_reset_req) |-> $past(s_r.en) && s_r.cnt == '0)
    else $error("reset request without enabled overflow");

  a_cause_kept: assert property (
    (i_sys_rst && !s_r.sys_q && s_r.cause) |=> s_r.rss_wdt [*2])
    else $error("watchdog reset cause not recorded");

  a_req_one_cycle: assert property (
    (o_wdt_reset_req && s_r.clks && !i_sys_rst) |=> !o_wdt_reset_req)
    else $error("bus clock reset request longer than one cycle");

  c_bus_overflow: cover property ($rose(o_wdt_reset_req) && s_r.clks);
  c_lpo_overflow: cover property ($rose(o_wdt_reset_req) && !s_r.clks);
  c_locked_write: cover property (ev_c[EV_LOCKED]);
  c_irq_raised:   cover property ($rose(o_irq));

endmodule // wdt_top
`default_nettype wire

/* bench/test_watchdog_timeout_reset.sv */
// Bench: register-level tests of the watchdog block over Avalon-MM
`timescale 1ns/10ps
`default_nettype none
module test_watchdog_timeout_reset;
  import wdt_pkg::*;
  // Shortened counts so the whole run stays brief
  localparam int LPO = 8;
  localparam int BS  = 5;
  localparam int BL  = 7;
  logic        i_clk;
  logic        i_arst_n;
  logic        i_sys_rst;
  logic        i_debug;
  logic        i_stop;
  logic [4:0]  i_avs_address;
  logic        i_avs_read;
  logic        i_avs_write;
  logic [31:0] i_avs_writedata;
  logic [3:0]  i_avs_byteenable;
  logic [31:0] o_avs_readdata;
  logic        o_avs_waitrequest;
  logic        o_irq;
  logic        o_wdt_reset_req;
  logic [31:0] rd;
  logic [31:0] held;
  int          n_errors;
  int          comparisons;
  int          n;
  int          ex;
  int          tol;

  wdt_top #(
    .P_LPO_CYCLES  (LPO),
    .P_BUS_SHORT_LG(BS),
    .P_BUS_LONG_LG (BL)
  ) wdt_top_i (
    .i_clk            (i_clk),
    .i_arst_n         (i_arst_n),
    .i_sys_rst        (i_sys_rst),
    .i_debug          (i_debug),
    .i_stop           (i_stop),
    .i_avs_address    (i_avs_address),
    .i_avs_read       (i_avs_read),
    .i_avs_write      (i_avs_write),
    .i_avs_writedata  (i_avs_writedata),
    .i_avs_byteenable (i_avs_byteenable),
    .o_avs_readdata   (o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest),
    .o_irq            (o_irq),
    .o_wdt_reset_req  (o_wdt_reset_req)
  );

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] got);
    comparisons++;
    if (got !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, e, got);
    end
  endtask

  // Request is held until waitrequest is sampled low at a rising edge;
  // outputs are read at the falling edge, where they have settled
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d);
    int t;
    logic w;
    t = 0;
    @(posedge i_clk);
    i_avs_read      <= ~wr;
    i_avs_write     <= wr;
    i_avs_address   <= a;
    i_avs_writedata <= d;
    do begin
      @(negedge i_clk);
      w  = o_avs_waitrequest;
      rd = o_avs_readdata;
      @(posedge i_clk);
      t++;
    end while (w !== 1'b0 && t < 50);
    chk("waitrequest", 32'h0, {31'h0, w});
    i_avs_read  <= 1'b0;
    i_avs_write <= 1'b0;
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [31:0] e,
                       input string what);
    bus(1'b0, a, 32'h0);
    chk(what, e, rd);
  endtask

  // Bounded wait for the reset request; n counts sampled edges
  task automatic wait_req(input int lim);
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
      @(negedge i_clk);
    end while (o_wdt_reset_req !== 1'b1 && n < lim);
  endtask

  task automatic sysrst();
    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
  endtask

  task automatic test_done();
    if (n_errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge i_clk);
    n_errors++;
    test_done();
  end

  initial begin
    i_arst_n = 1'b0;
    i_sys_rst = 1'b0;
    i_debug = 1'b0;
    i_stop = 1'b0;
    i_avs_address = 5'h00;
    i_avs_read = 1'b0;
    i_avs_write = 1'b0;
    i_avs_writedata = 32'h0;
    i_avs_byteenable = 4'hf;
    n_errors = 0;
    comparisons = 0;
    repeat (8) @(posedge i_clk);
    i_arst_n <= 1'b1;
    rdchk(ADR_OPT1, 32'h3, "options one");
    rdchk(ADR_OPT2, 32'h0, "options two");
    rdchk(ADR_RSS, 32'h0, "reset source");
    rdchk(ADR_IMASK, 32'h0, "mask");
    rdchk(5'h18, 32'h0, "unmapped");
    bus(1'b1, ADR_IMASK, 32'h1);
    // All four clock and length encodings, each locked after a reset
    for (int i = 0; i < 4; i++) begin
      sysrst();
      rdchk(ADR_RSS, {31'h0, i > 0}, "cause bit");
      bus(1'b1, ADR_OPT2, {31'h0, i[1]});
      bus(1'b1, ADR_OPT1, {30'h0, i[0], 1'b1});
      wait_req(3000);
      ex = i[1] ? (1 << (i[0] ? BL : BS))
                : (1 << (i[0] ? LOG_LPO_LONG : LOG_LPO_SHORT)) * LPO;
      tol = i[1] ? 0 : LPO;
      chk("overflow gap", 32'h1, {31'h0, n + tol >= ex && n <= ex + tol});
      @(posedge i_clk);
      @(negedge i_clk);
      if (i[1]) chk("request width", 32'h0, {31'h0, o_wdt_reset_req});
      chk("irq raised", 32'h1, {31'h0, o_irq});
      rdchk(ADR_ISTS, 32'h1, "overflow status");
      repeat (2) @(posedge i_clk);
      chk("irq cleared", 32'h0, {31'h0, o_irq});
    end
    bus(1'b1, ADR_OPT1, 32'h0);
    rdchk(ADR_OPT1, 32'h3, "locked options");
    repeat (50) @(posedge i_clk);
    bus(1'b1, ADR_RSS, 32'hffffffff); // main flow services
    bus(1'b0, ADR_CNT, 32'h0);
    chk("serviced count", 32'h1, {31'h0, rd < 32'h5});
    rdchk(ADR_RSS, 32'h1, "status kept");
    rdchk(ADR_ISTS, 32'h6, "service and lock events");
    i_debug <= 1'b1;
    bus(1'b0, ADR_CNT, 32'h0);
    held = rd;
    repeat (20) @(posedge i_clk);
    rdchk(ADR_CNT, held, "debug hold");
    i_debug <= 1'b0;
    i_stop <= 1'b1;
    bus(1'b0, ADR_CNT, 32'h0);
    held = rd;
    repeat (20) @(posedge i_clk);
    rdchk(ADR_CNT, held, "bus stop hold");
    i_stop <= 1'b0;
    repeat (5) @(posedge i_clk);
    bus(1'b0, ADR_CNT, 32'h0);
    chk("resumed", 32'h1, {31'h0, rd > held});
    // Low-power clock: stop entry wipes the count
    sysrst();
    bus(1'b1, ADR_OPT2, 32'h0);
    bus(1'b1, ADR_OPT1, 32'h3);
    repeat (40) @(posedge i_clk);
    bus(1'b0, ADR_CNT, 32'h0);
    chk("low-power counting", 32'h1, {31'h0, rd != 32'h0});
    i_stop <= 1'b1;
    repeat (2) @(posedge i_clk);
    rdchk(ADR_CNT, 32'h0, "stop clears");
    i_stop <= 1'b0;
    // Disabled watchdog on the short bus count never fires
    sysrst();
    bus(1'b1, ADR_OPT2, 32'h1);
    bus(1'b1, ADR_OPT1, 32'h0);
    wait_req(300);
    chk("no request", 32'h0, {31'h0, o_wdt_reset_req});
    rdchk(ADR_CNT, 32'h0, "disabled count");
    test_done();
  end
endmodule // test_watchdog_timeout_reset
`default_nettype wire
